// ==== verilog/fan_duty_ramp_limiter.sv ====
// Per-output duty slew limiter with its register file and three fan drive outputs.
`timescale 1ns/1ps
`include "fan_ramp_cfg.svh"
// What this block does
// - Bit 3 of slew_control_a enables slew limiting on fan output one.
// - Bit 7 of slew_control_b enables slew limiting on fan output two.
// - Bit 3 of slew_control_b enables slew limiting on fan output three.
// - Each drive period has 255 slots; duty N stays high N slots.
// - Step sizes are only 1, 2, 3, 5, 8, 12, 24 or 48 slots.
// - Target above previous duty: previous plus step, but not above the target, becomes output duty.
// - Target below previous duty: previous minus step, but not below the target, becomes output duty.
// - Each stepped result is stored as previous duty for next comparison.
// - Three read/write current duty registers from 0x30, reset 0x00.
// - slew_control_a bits 2:0 pick output one step, codes 0..7.
// - slew_control_b bits 6:4 pick output two step, same mapping.
// - slew_control_b bits 2:0 pick output three step, same mapping.
// - Config bit 3 set slows that output's ramp by SLOW_FACTOR, four by default.
module fan_duty_ramp_limiter
  import fan_ramp_pkg::*;
#(
  parameter int SLOW_FACTOR = `SLOW_FACTOR_DEF,
  parameter int SLOT_CYCLES = 1
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // Host register port
  input wire reg_req_t reg_req,
  output logic [7:0] reg_rdata,
  // Newly calculated targets and their update strobe
  input wire fan_targets_t calc_target,
  input wire logic calc_update,
  // Fan drive pins
  output logic fan_drive_one,
  output logic fan_drive_two,
  output logic fan_drive_three
);

  logic rst_meta_r;
  logic rst_n_sync;
  logic [7:0] duty_r [3];
  logic [7:0] ceiling_r [3];
  logic [7:0] fan_cfg_r [3];
  logic [7:0] slew_a_r;
  logic [7:0] slew_b_r;
  logic [1:0] slow_cnt_r [3];
  logic [7:0] target [3];
  logic [7:0] tgt_cap [3];
  logic [8:0] step [3];
  logic [2:0] sel [3];
  logic slew_en [3];
  logic fire [3];
  logic [7:0] duty_nxt [3];

  // The slow counter is two bits wide, so larger factors cannot be served.
  if (SLOW_FACTOR < 1 || SLOW_FACTOR > 4)
  begin : g_bad_slow_factor
    $error("SLOW_FACTOR must lie in 1..4");
  end

  // ==========================================================
  // Helpers
  // eight step sizes
  function automatic logic [8:0] step_of(input logic [2:0] code);
    case (code)
      3'h0: step_of = `STEP_C0;
      3'h1: step_of = `STEP_C1;
      3'h2: step_of = `STEP_C2;
      3'h3: step_of = `STEP_C3;
      3'h4: step_of = `STEP_C4;
      3'h5: step_of = `STEP_C5;
      3'h6: step_of = `STEP_C6;
      default: step_of = `STEP_C7;
    endcase
  endfunction

  function automatic logic [7:0] slew_to(input logic [7:0] prev, input logic [7:0] tgt,
                                          input logic [8:0] stp);
    logic [8:0] gap;
    gap = 9'h000;
    if (tgt > prev)
    begin
      gap = {1'b0, tgt} - {1'b0, prev};
      slew_to = (gap <= stp) ? tgt : 8'(({1'b0, prev} + stp));
    end
    else if (tgt < prev)
    begin
      gap = {1'b0, prev} - {1'b0, tgt};
      slew_to = (gap <= stp) ? tgt : 8'(({1'b0, prev} - stp));
    end
    else
      slew_to = prev;
  endfunction

  // ==========================================================
  // Reset release
  // Release goes through two flops so every register leaves reset on the same edge.
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rst_meta_r <= 1'b0;
      rst_n_sync <= 1'b0;
    end
    else
    begin
      rst_meta_r <= 1'b1;
      rst_n_sync <= rst_meta_r;
    end
  end

  // ==========================================================
  // Field decode
  // enable bits
  assign slew_en[0] = slew_a_r[`SLEW_A_EN1_BIT];
  assign slew_en[1] = slew_b_r[`SLEW_B_EN2_BIT];
  assign slew_en[2] = slew_b_r[`SLEW_B_EN3_BIT];
  assign sel[0] = slew_a_r[`SLEW_A_SEL1_HI:`SLEW_A_SEL1_LO];
  assign sel[1] = slew_b_r[`SLEW_B_SEL2_HI:`SLEW_B_SEL2_LO];
  assign sel[2] = slew_b_r[`SLEW_B_SEL3_HI:`SLEW_B_SEL3_LO];
  assign target[0] = calc_target.one;
  assign target[1] = calc_target.two;
  assign target[2] = calc_target.three;

  // Targets are capped by each output's ceiling before any stepping.
  always_comb
  begin
    for (int c = 0; c < 3; c++)
    begin
      step[c] = step_of(sel[c]);
      tgt_cap[c] = (target[c] > ceiling_r[c]) ? ceiling_r[c] : target[c];
      fire[c] = calc_update && (!fan_cfg_r[c][`FAN_CFG_SLOW_BIT] ||
                slow_cnt_r[c] == 2'(SLOW_FACTOR - 1));
      if (!slew_en[c])
        duty_nxt[c] = calc_update ? tgt_cap[c] : duty_r[c];
      else
        duty_nxt[c] = fire[c] ? slew_to(duty_r[c], tgt_cap[c], step[c]) : duty_r[c];
    end
  end

  // ==========================================================
  // Slow divider
  // Counts updates so a slowed output steps once per SLOW_FACTOR updates.
  always_ff @(posedge ref_clk or negedge rst_n_sync)
  begin
    if (!rst_n_sync)
      for (int c = 0; c < 3; c++) slow_cnt_r[c] <= 2'h0;
    else
      for (int c = 0; c < 3; c++)
        if (calc_update)
          slow_cnt_r[c] <= fire[c] ? 2'h0 : slow_cnt_r[c] + 2'h1;
  end

  // ==========================================================
  // Current duty registers
  // store previous duty
  always_ff @(posedge ref_clk or negedge rst_n_sync)
  begin
    if (!rst_n_sync)
      for (int c = 0; c < 3; c++) duty_r[c] <= `RST_DUTY_NOW;
    else
      for (int c = 0; c < 3; c++)
        if (reg_req.wr && reg_req.addr == 8'(`OFS_DUTY_NOW_1 + c))
          duty_r[c] <= reg_req.wdata;
        else
          duty_r[c] <= duty_nxt[c];
  end

  // ==========================================================
  // Configuration registers
  always_ff @(posedge ref_clk or negedge rst_n_sync)
  begin
    if (!rst_n_sync)
    begin
      for (int c = 0; c < 3; c++)
      begin
        ceiling_r[c] <= `RST_CEILING;
        fan_cfg_r[c] <= `RST_FAN_CFG;
      end
      slew_a_r <= `RST_SLEW;
      slew_b_r <= `RST_SLEW;
    end
    else if (reg_req.wr)
    begin
      for (int c = 0; c < 3; c++)
      begin
        if (reg_req.addr == 8'(`OFS_CEILING_1 + c))
          ceiling_r[c] <= reg_req.wdata;
        if (reg_req.addr == 8'(`OFS_FAN_CFG_1 + c))
          fan_cfg_r[c] <= reg_req.wdata;
      end
      if (reg_req.addr == `OFS_SLEW_A)
        slew_a_r <= reg_req.wdata;
      if (reg_req.addr == `OFS_SLEW_B)
        slew_b_r <= reg_req.wdata;
    end
  end

  // ==========================================================
  // Read data
  // Read data trails the address by one clock; unmapped addresses read zero.
  always_ff @(posedge ref_clk or negedge rst_n_sync)
  begin
    if (!rst_n_sync)
      reg_rdata <= `RD_UNMAPPED;
    else
      case (reg_req.addr)
        `OFS_DUTY_NOW_1: reg_rdata <= duty_r[0];
        `OFS_DUTY_NOW_2: reg_rdata <= duty_r[1];
        `OFS_DUTY_NOW_3: reg_rdata <= duty_r[2];
        `OFS_CEILING_1: reg_rdata <= ceiling_r[0];
        `OFS_CEILING_2: reg_rdata <= ceiling_r[1];
        `OFS_CEILING_3: reg_rdata <= ceiling_r[2];
        `OFS_FAN_CFG_1: reg_rdata <= fan_cfg_r[0];
        `OFS_FAN_CFG_2: reg_rdata <= fan_cfg_r[1];
        `OFS_FAN_CFG_3: reg_rdata <= fan_cfg_r[2];
        `OFS_SLEW_A: reg_rdata <= slew_a_r;
        `OFS_SLEW_B: reg_rdata <= slew_b_r;
        default: reg_rdata <= `RD_UNMAPPED;
      endcase
  end

  // ==========================================================
  // Drive generators
  // slot based outputs
  fan_slot_pwm #(.SLOT_CYCLES(SLOT_CYCLES)) u_pwm_one (
    .ref_clk(ref_clk), .arst_n(rst_n_sync), .duty(duty_r[0]), .drive(fan_drive_one));
  fan_slot_pwm #(.SLOT_CYCLES(SLOT_CYCLES)) u_pwm_two (
    .ref_clk(ref_clk), .arst_n(rst_n_sync), .duty(duty_r[1]), .drive(fan_drive_two));
  fan_slot_pwm #(.SLOT_CYCLES(SLOT_CYCLES)) u_pwm_three (
    .ref_clk(ref_clk), .arst_n(rst_n_sync), .duty(duty_r[2]), .drive(fan_drive_three));

  // ==========================================================
  // Checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n_sync);

  // With the enable bit of output one set, no update may move its duty by more than one step.
  property p_en_map;
    slew_a_r[`SLEW_A_EN1_BIT] && calc_update && !reg_req.wr
      |=> ((duty_r[0] > $past(duty_r[0])) ? {1'b0, duty_r[0]} - {1'b0, $past(duty_r[0])}
          : {1'b0, $past(duty_r[0])} - {1'b0, duty_r[0]}) <= $past(step[0]);
  endproperty
  a_en_map: assert property (p_en_map) else $error("enable bit mapping wrong");

  property p_step_set;
    step[0] inside {9'd1, 9'd2, 9'd3, 9'd5, 9'd8, 9'd12, 9'd24, 9'd48};
  endproperty
  a_step_set: assert property (p_step_set) else $error("illegal step size");

  property p_step_fast;
    sel[1] == 3'h7 |-> step[1] == 9'd48;
  endproperty
  a_step_fast: assert property (p_step_fast) else $error("code 7 not 48 slots");

  property p_reset_duty;
    $rose(rst_n_sync) |-> duty_r[0] == 8'h00 && duty_r[1] == 8'h00 && duty_r[2] == 8'h00;
  endproperty
  a_reset_duty: assert property (p_reset_duty) else $error("duty not zero after reset");

  property p_step_up;
    slew_en[0] && fire[0] && !reg_req.wr && {1'b0, tgt_cap[0]} > {1'b0, duty_r[0]} + step[0]
      |=> {1'b0, duty_r[0]} == {1'b0, $past(duty_r[0])} + $past(step[0]);
  endproperty
  a_step_up: assert property (p_step_up) else $error("up step wrong");

  property p_step_down;
    slew_en[0] && fire[0] && !reg_req.wr && {1'b0, tgt_cap[0]} + step[0] < {1'b0, duty_r[0]}
      |=> {1'b0, duty_r[0]} + $past(step[0]) == {1'b0, $past(duty_r[0])};
  endproperty
  a_step_down: assert property (p_step_down) else $error("down step wrong");

  property p_no_overshoot;
    slew_en[0] && fire[0] && !reg_req.wr && tgt_cap[0] > duty_r[0]
      |=> duty_r[0] <= $past(tgt_cap[0]);
  endproperty
  a_no_overshoot: assert property (p_no_overshoot) else $error("step overshot target");

  property p_follow;
    !slew_en[1] && calc_update && !reg_req.wr |=> duty_r[1] == $past(tgt_cap[1]);
  endproperty
  a_follow: assert property (p_follow) else $error("disabled output not following");

  property p_hold;
    !calc_update && !reg_req.wr ##1 !calc_update && !reg_req.wr |-> $stable(duty_r[2]);
  endproperty
  a_hold: assert property (p_hold) else $error("duty moved without update");

  property p_slow;
    fan_cfg_r[0][3] && slew_en[0] && calc_update && slow_cnt_r[0] != 2'(SLOW_FACTOR - 1)
      && !reg_req.wr |=> $stable(duty_r[0]);
  endproperty
  a_slow: assert property (p_slow) else $error("slowed output stepped early");

endmodule // fan_duty_ramp_limiter

// ==== verilog/fan_ramp_cfg.svh ====
// Register offsets, field positions, reset values and step table of the fan duty ramp limiter.
`ifndef FAN_RAMP_CFG_SVH
`define FAN_RAMP_CFG_SVH

// ==========================================================
// Register offsets
`define OFS_DUTY_NOW_1 8'h30
`define OFS_DUTY_NOW_2 8'h31
`define OFS_DUTY_NOW_3 8'h32
`define OFS_CEILING_1 8'h38
`define OFS_CEILING_2 8'h39
`define OFS_CEILING_3 8'h3a
`define OFS_FAN_CFG_1 8'h5c
`define OFS_FAN_CFG_2 8'h5d
`define OFS_FAN_CFG_3 8'h5e
`define OFS_SLEW_A 8'h62
`define OFS_SLEW_B 8'h63

// ==========================================================
// Reset values
`define RST_DUTY_NOW 8'h00
`define RST_CEILING 8'hff
`define RST_FAN_CFG 8'h82
`define RST_SLEW 8'h00
`define RD_UNMAPPED 8'h00

// ==========================================================
// Field positions
`define SLEW_A_EN1_BIT 3
`define SLEW_A_SEL1_HI 2
`define SLEW_A_SEL1_LO 0
`define SLEW_B_EN2_BIT 7
`define SLEW_B_SEL2_HI 6
`define SLEW_B_SEL2_LO 4
`define SLEW_B_EN3_BIT 3
`define SLEW_B_SEL3_HI 2
`define SLEW_B_SEL3_LO 0
`define FAN_CFG_SLOW_BIT 3

// ==========================================================
// Slot counts
`define SLOTS_PER_PERIOD 8'd255
`define LAST_SLOT 8'd254
`define STEP_C0 9'd1
`define STEP_C1 9'd2
`define STEP_C2 9'd3
`define STEP_C3 9'd5
`define STEP_C4 9'd8
`define STEP_C5 9'd12
`define STEP_C6 9'd24
`define STEP_C7 9'd48
`define SLOW_FACTOR_DEF 4

`endif

// ==== verilog/fan_ramp_pkg.sv ====
// Types shared by the fan duty ramp limiter files.
package fan_ramp_pkg;

  // Host register access request.
  typedef struct packed {
    logic [7:0] addr;
    logic wr;
    logic [7:0] wdata;
  } reg_req_t;

  // Newly calculated duty targets, one byte per fan output.
  typedef struct packed {
    logic [7:0] three;
    logic [7:0] two;
    logic [7:0] one;
  } fan_targets_t;

endpackage

// ==== verilog/fan_slot_pwm.sv ====
// Pulse-width generator splitting each period into 255 time slots.
`timescale 1ns/1ps
`include "fan_ramp_cfg.svh"
module fan_slot_pwm #(
  parameter int SLOT_CYCLES = 1
) (
  // Clock and synchronised reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // Duty in slots
  input wire logic [7:0] duty,
  // Drive pin
  output logic drive
);

  logic [15:0] div_r;
  logic [7:0] slot_r;
  logic [7:0] duty_hold_r;

  // Refuse a slot length that the 16-bit divider cannot count.
  if (SLOT_CYCLES < 1 || SLOT_CYCLES > 65535)
  begin : g_bad_slot_cycles
    $error("SLOT_CYCLES out of range");
  end

  // ==========================================================
  // Slot timing
  // Divider sets the length of one slot in clock cycles.
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      div_r <= 16'h0000;
    else if (div_r == 16'(SLOT_CYCLES - 1))
      div_r <= 16'h0000;
    else
      div_r <= div_r + 16'h0001;
  end

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      slot_r <= 8'h00;
    else if (div_r == 16'(SLOT_CYCLES - 1))
      slot_r <= (slot_r == `LAST_SLOT) ? 8'h00 : slot_r + 8'h01;
  end

  // Duty is taken only at a period boundary, so no period is ever cut short or doubled.
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      duty_hold_r <= 8'h00;
    else if (slot_r == `LAST_SLOT && div_r == 16'(SLOT_CYCLES - 1))
      duty_hold_r <= duty;
  end

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      drive <= 1'b0;
    else
      drive <= (slot_r < duty_hold_r);
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);

  property p_slot_range;
    slot_r <= `LAST_SLOT;
  endproperty
  a_slot_range: assert property (p_slot_range) else $error("slot count passed 254");

  property p_drive_level;
    1'b1 |=> drive == ($past(slot_r) < $past(duty_hold_r));
  endproperty
  a_drive_level: assert property (p_drive_level) else $error("drive level wrong");

endmodule // fan_slot_pwm

// ==== dv/fan_model.sv ====
// Behavioural fan that measures the high time of each drive period.
`timescale 1ns/1ps
module fan_model (
  // Clock
  input wire logic ref_clk,
  // Drive pin from the controller
  input wire logic drive,
  // High clocks seen in the last complete period
  output logic [15:0] high_cycles
);
  // ==========================================================
  // Period measurement
  logic [15:0] run_r;
  logic drive_d_r;

  // Start from a quiet pin so the first edge is seen.
  initial
  begin
    run_r = 16'h0000;
    drive_d_r = 1'b0;
    high_cycles = 16'h0000;
  end

  // A period starts at each rising edge; a duty of zero never rises and keeps the old figure.
  always @(posedge ref_clk)
  begin
    drive_d_r <= drive;
    if (drive && !drive_d_r)
    begin
      high_cycles <= run_r;
      run_r <= 16'h0001;
    end
    else if (drive)
      run_r <= run_r + 16'h0001;
  end
endmodule // fan_model

// ==== dv/test_fan_duty_ramp_limiter.sv ====
// Self-checking bench for the fan duty ramp limiter.
`timescale 1ns/1ps
`include "fan_ramp_cfg.svh"
module test_fan_duty_ramp_limiter
  import fan_ramp_pkg::*;
;
  // ==========================================================
  // Signals and design
  localparam int SLOTS = 1;
  typedef struct packed {
    logic en;
    logic [2:0] code;
    logic [7:0] start;
    logic [7:0] target;
    logic [7:0] exp_duty;
  } row_t;
  logic ref_clk = 1'b0;
  logic arst_n = 1'b0;
  reg_req_t reg_req = '0;
  logic [7:0] reg_rdata;
  fan_targets_t calc_target = '0;
  logic calc_update = 1'b0;
  logic fan_drive_one, fan_drive_two, fan_drive_three;
  logic [15:0] hc1, hc2, hc3;
  int num_errors = 0;
  int compares = 0;
  row_t rows [11];
  logic [7:0] rst_addr [10];
  logic [7:0] rst_val [10];

  fan_duty_ramp_limiter #(.SLOW_FACTOR(4), .SLOT_CYCLES(SLOTS)) fan_duty_ramp_limiter_i (
    .ref_clk(ref_clk), .arst_n(arst_n), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .calc_target(calc_target), .calc_update(calc_update), .fan_drive_one(fan_drive_one),
    .fan_drive_two(fan_drive_two), .fan_drive_three(fan_drive_three));
  fan_model fan_model_one_i (.ref_clk(ref_clk), .drive(fan_drive_one), .high_cycles(hc1));
  fan_model fan_model_two_i (.ref_clk(ref_clk), .drive(fan_drive_two), .high_cycles(hc2));
  fan_model fan_model_three_i (.ref_clk(ref_clk), .drive(fan_drive_three), .high_cycles(hc3));

  // A 10 MHz clock.
  always #50 ref_clk = ~ref_clk;

  // ==========================================================
  // Tasks
  task automatic chk_reg(input logic [7:0] g, input logic [7:0] e);
    compares++;
    if (g !== e)
    begin
      num_errors++;
      $display("[ERR] t=%0t reg got %h exp %h", $time, g, e);
    end
  endtask

  task automatic chk_pwm(input logic [15:0] g, input logic [15:0] e);
    compares++;
    if (g !== e)
    begin
      num_errors++;
      $display("[ERR] t=%0t pwm got %h exp %h", $time, g, e);
    end
  endtask

  // The strobe drops one edge later, so each write is taken exactly once.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_req <= '{addr: a, wr: 1'b1, wdata: d};
    @(posedge ref_clk);
    reg_req.wr <= 1'b0;
  endtask

  // Read data follows the sampled address by one edge; one spare edge is allowed.
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge ref_clk);
    reg_req.addr <= a;
    @(posedge ref_clk);
    @(posedge ref_clk);
    #1 chk_reg(reg_rdata, e);
  endtask

  // Holding the strobe for n edges gives n back-to-back updates.
  task automatic upd(input logic [7:0] t, input int n);
    @(posedge ref_clk);
    calc_target <= {t, t, t};
    calc_update <= 1'b1;
    repeat (n) @(posedge ref_clk);
    calc_update <= 1'b0;
  endtask

  task automatic end_of_test();
    $display("compares=%0d num_errors=%0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // A hang costs one mismatch and ends the run the ordinary way.
  initial
  begin
    repeat (60000) @(posedge ref_clk);
    num_errors++;
    end_of_test();
  end

  // ==========================================================
  // Main sequence
  initial
  begin
    rows = '{'{1'b1, 3'h0, 8'h64, 8'hc8, 8'h65}, '{1'b1, 3'h1, 8'h64, 8'h00, 8'h62},
             '{1'b1, 3'h2, 8'h64, 8'hc8, 8'h67}, '{1'b1, 3'h3, 8'h64, 8'h00, 8'h5f},
             '{1'b1, 3'h4, 8'h64, 8'hc8, 8'h6c}, '{1'b1, 3'h5, 8'h64, 8'h00, 8'h58},
             '{1'b1, 3'h6, 8'h64, 8'hc8, 8'h7c}, '{1'b1, 3'h7, 8'h64, 8'h00, 8'h34},
             '{1'b1, 3'h7, 8'h64, 8'h78, 8'h78}, '{1'b0, 3'h7, 8'h64, 8'hc8, 8'hc8},
             '{1'b1, 3'h4, 8'h64, 8'h64, 8'h64}};
    rst_addr = '{8'h30, 8'h31, 8'h32, 8'h38, 8'h39, 8'h3a, 8'h5c, 8'h62, 8'h63, 8'h40};
    rst_val = '{8'h00, 8'h00, 8'h00, 8'hff, 8'hff, 8'hff, 8'h82, 8'h00, 8'h00, 8'h00};
    repeat (20) @(posedge ref_clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    // Reset values, with a write to an unmapped place that must leave no trace.
    wr(8'h40, 8'h5a);
    for (int i = 0; i < 10; i++)
      rd(rst_addr[i], rst_val[i]);
    // Each row runs on each output while the other two stay unlimited.
    for (int o = 0; o < 3; o++)
      for (int r = 0; r < 11; r++)
      begin
        wr(`OFS_SLEW_A, (o == 0) ? {4'h0, rows[r].en, rows[r].code} : 8'h00);
        wr(`OFS_SLEW_B, (o == 1) ? {rows[r].en, rows[r].code, 4'h0} :
                        (o == 2) ? {4'h0, rows[r].en, rows[r].code} : 8'h00);
        wr(`OFS_DUTY_NOW_1 + 8'(o), rows[r].start);
        upd(rows[r].target, 1);
        for (int k = 0; k < 3; k++)
          rd(`OFS_DUTY_NOW_1 + 8'(k), (k == o) ? rows[r].exp_duty : rows[r].target);
      end
    // Three back-to-back updates of 8 slots each stop on the target of 20.
    wr(`OFS_SLEW_A, 8'h0c);
    wr(`OFS_SLEW_B, 8'h00);
    wr(`OFS_DUTY_NOW_1, 8'h00);
    upd(8'h14, 3);
    rd(`OFS_DUTY_NOW_1, 8'h14);
    // With the slow bit set only one update in four moves the duty.
    wr(`OFS_FAN_CFG_1, 8'h8a);
    wr(`OFS_SLEW_A, 8'h08);
    wr(`OFS_DUTY_NOW_1, 8'h00);
    upd(8'hc8, 4);
    rd(`OFS_DUTY_NOW_1, 8'h01);
    upd(8'hc8, 4);
    rd(`OFS_DUTY_NOW_1, 8'h02);
    // A target above the ceiling only reaches the ceiling on an unlimited output.
    wr(`OFS_CEILING_2, 8'h40);
    upd(8'hc8, 1);
    rd(`OFS_DUTY_NOW_2, 8'h40);
    wr(`OFS_CEILING_2, 8'hff);
    // High time per period at the pins, including the one-slot and 254-slot cases.
    wr(`OFS_SLEW_A, 8'h00);
    wr(`OFS_DUTY_NOW_1, 8'h55);
    wr(`OFS_DUTY_NOW_2, 8'h01);
    wr(`OFS_DUTY_NOW_3, 8'hfe);
    repeat (800 * SLOTS) @(posedge ref_clk);
    // The figures are read after the edge so the fan model has settled.
    #1;
    chk_pwm(hc1, 16'(16'h0055 * SLOTS));
    chk_pwm(hc2, 16'(16'h0001 * SLOTS));
    chk_pwm(hc3, 16'(16'h00fe * SLOTS));
    // A second reset in mid-run must bring current duty registers one and three back to zero.
    @(posedge ref_clk);
    arst_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    rd(`OFS_DUTY_NOW_1, 8'h00);
    rd(`OFS_DUTY_NOW_3, 8'h00);
    end_of_test();
  end
endmodule // test_fan_duty_ramp_limiter
